//--- common/ietsr_params.svh
`ifndef IETSR_PARAMS_SVH
`define IETSR_PARAMS_SVH

// ----------------------------------------------------------------
// station geometry
// ----------------------------------------------------------------
`define IETSR_SLOTS        12
`define IETSR_CH_PER_SLOT  32
`define IETSR_CHANS        384
`define IETSR_SLOT_BASE    4'h4
`define IETSR_SLOT_SPECIAL 4'h2
`define IETSR_STATION_MAX  8'h80

// ----------------------------------------------------------------
// message list
// ----------------------------------------------------------------
`define IETSR_MSG_PER_REC  5'h14
`define IETSR_RECS         4'hf
`define IETSR_MSG_W        48
`define IETSR_MSG_SLOT_LSB 44
`define IETSR_MSG_ID_LSB   39
`define IETSR_MSG_INC_BIT  38
`define IETSR_EV_STOP      5'h01
`define IETSR_EV_FRAME     5'h02

// ----------------------------------------------------------------
// input image
// ----------------------------------------------------------------
`define IETSR_STD_BYTES    16
`define IETSR_IMG_BYTES    32
`define IETSR_ADD_BYTES    16
`define IETSR_ADD_DIV      4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IETSR_CLK_NS       25
`define IETSR_TICK_NS      1000000
`define IETSR_TICK_CYC     ((`IETSR_TICK_NS) / (`IETSR_CLK_NS))
`define IETSR_FINE_MODS    4'h8
`define IETSR_COARSE_MODS  4'hc

`endif

//--- common/ietsr_pkg.sv
`include "ietsr_params.svh"
`default_nettype none
package ietsr_pkg;

    // readout sequencer, gray along idle -> run -> tail
    typedef enum logic [1:0] {
        ietsr_rd_idle = 2'h0,
        ietsr_rd_run  = 2'h1,
        ietsr_rd_tail = 2'h3
    } ietsr_rd_t;

    // complete state of the recorder
    typedef struct packed {
        logic [`IETSR_CHANS-1:0]     prev;
        logic [8:0]                  scan;
        logic [7:0]                  elig;
        logic                        run;
        logic                        frm;
        logic [3:0]                  ev_pend;
        logic [31:0]                 tick;
        logic [31:0]                 now;
        logic [3:0]                  wr_rec;
        logic [4:0]                  wr_cnt;
        logic [3:0]                  nrec;
        logic [3:0]                  rd_rec;
        logic [14:0][4:0]            rec_len;
        ietsr_rd_t                   rd;
        logic                        rd_pend;
        logic [4:0]                  rd_idx;
        logic [4:0]                  rd_len;
        logic                        msg_valid;
        logic                        msg_last;
        logic                        rec_empty;
        logic                        overflow;
        logic                        irq;
        logic [`IETSR_IMG_BYTES*8-1:0] img;
        logic [`IETSR_ADD_BYTES*8-1:0] add;
        logic [3:0]                  add_cnt;
        logic                        boot_bank;
        logic                        rst_pend;
        logic                        restart;
        logic                        coarse;
    } ietsr_state_t;

endpackage
`default_nettype wire

//--- hw/ietsr_mem.sv
`include "ietsr_params.svh"
`default_nettype none
module ietsr_mem #(
    parameter int unsigned W  = `IETSR_MSG_W,
    parameter int unsigned AW = 9
) (
    // clocking
    input  wire logic          clk,
    input  wire logic          ce,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata_q
);

    logic [W-1:0] mem [0:(1<<AW)-1];

    // message storage, registered read
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_q <= mem[raddr];
        end
    end

endmodule // ietsr_mem
`default_nettype wire

//--- hw/ietsr_top.sv
`include "ietsr_params.svh"
`default_nettype none
// Overview of operation
// - input image holds up to 32 bytes per station
// - bytes 16..31 refresh and substitute exactly like bytes 0..15
// - starting or pulled module yields zero in expanded input data
// - standard and additional data each consistent; additional refreshed less often
// - at most 32 stamped channels per slot, 128 per station
// - only legacy-series digital inputs are stamped, native modules never
// - both edges stamped; polarity picks which edge is incoming
// - each change timed and listed; 20 messages per record, 15 records
// - message holds slot 4..15, channel, incoming/outgoing, time
// - interrupt to master while messages pending or record full
// - stamping stop and time frame loss give slot-2 special messages
// - 1 ms time base for any module count; above 8 modules only res_coarse is raised
// - automatic activation resets into new firmware after good load
// - failed update keeps booting the previous valid image
// - redundant units update without disturbing the running application
module ietsr_top #(
    parameter int unsigned TICK_CYC = `IETSR_TICK_CYC,
    parameter int unsigned ADD_DIV  = `IETSR_ADD_DIV
) (
    // clock, reset, enable
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    // monitored inputs and their setup
    input  wire logic [`IETSR_CHANS-1:0]       digital_input_channel,
    input  wire logic [`IETSR_CHANS-1:0]       stamp_enable,
    input  wire logic [`IETSR_CHANS-1:0]       incoming_on_rise,
    input  wire logic [`IETSR_SLOTS-1:0]       legacy_slot,
    input  wire logic [3:0]                    modules_fitted,
    // time base and stamping control
    input  wire logic                          stamp_run,
    input  wire logic                          time_frame_ok,
    input  wire logic                          time_load,
    input  wire logic [31:0]                   time_in,
    // record readout toward the master
    input  wire logic                          rd_req,
    output logic      [`IETSR_MSG_W-1:0]       msg_data,
    output logic                               msg_valid,
    output logic                               msg_last,
    output logic                               rec_empty,
    output logic                               overflow,
    output logic                               irq,
    // input image
    input  wire logic                          std_upd,
    input  wire logic [`IETSR_STD_BYTES*8-1:0] std_in,
    input  wire logic                          std_ok,
    input  wire logic [`IETSR_STD_BYTES*8-1:0] ext_in,
    input  wire logic                          ext_ok,
    input  wire logic [`IETSR_ADD_BYTES*8-1:0] add_in,
    input  wire logic                          add_ok,
    output logic      [`IETSR_IMG_BYTES*8-1:0] img_data,
    output logic      [`IETSR_ADD_BYTES*8-1:0] add_data,
    // firmware update and status
    input  wire logic                          fw_done,
    input  wire logic                          fw_ok,
    input  wire logic                          auto_activate,
    input  wire logic                          redundant,
    input  wire logic                          unit_active,
    output logic                               restart_req,
    output logic                               boot_bank,
    output logic                               res_coarse,
    output logic      [31:0]                   now_ms
);

    localparam int unsigned HALF = `IETSR_STD_BYTES * 8;

    ietsr_pkg::ietsr_state_t st_q;
    ietsr_pkg::ietsr_state_t st_d;
    logic                     wr_en;
    logic [8:0]               waddr;
    logic [`IETSR_MSG_W-1:0]  wr_msg;
    logic [8:0]               raddr;

    // next record index on the ring of records
    function automatic logic [3:0] nxt_rec(input logic [3:0] r);
        nxt_rec = (r == (`IETSR_RECS - 4'h1)) ? 4'h0 : r + 4'h1;
    endfunction

    // pack slot, channel or event id, direction and time into one message
    function automatic logic [`IETSR_MSG_W-1:0] mk_msg(input logic [3:0] slot, input logic [4:0] id,
                                                        input logic inc, input logic [31:0] t);
        mk_msg = '0;
        mk_msg[`IETSR_MSG_SLOT_LSB +: 4] = slot;
        mk_msg[`IETSR_MSG_ID_LSB +: 5]   = id;
        mk_msg[`IETSR_MSG_INC_BIT]       = inc;
        mk_msg[31:0]                     = t;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] ev;
        logic       have;
        logic [3:0] inc_n;
        logic [3:0] dec_n;
        logic [8:0] idx;
        logic       cur;
        logic       eligible;
        logic       fw_new;
        logic       allow;
        ev       = '0;
        have     = 1'b0;
        inc_n    = 4'h0;
        dec_n    = 4'h0;
        idx      = st_q.scan;
        cur      = 1'b0;
        eligible = 1'b0;
        fw_new   = 1'b0;
        allow    = 1'b0;
        st_d     = st_q;
        wr_en    = 1'b0;
        wr_msg   = '0;
        waddr    = {st_q.wr_rec, st_q.wr_cnt};
        raddr    = {st_q.rd_rec, st_q.rd_idx};
        st_d.msg_valid = 1'b0;
        st_d.msg_last  = 1'b0;
        st_d.rec_empty = 1'b0;
        st_d.restart   = 1'b0;
        // millisecond time base, loadable from the time frame
        if (time_load) begin
            st_d.now  = time_in;
            st_d.tick = '0;
        end else if (st_q.tick >= TICK_CYC - 1) begin
            st_d.tick = '0;
            st_d.now  = st_q.now + 32'h1;
        end else begin
            st_d.tick = st_q.tick + 32'h1;
        end
        st_d.coarse = modules_fitted > `IETSR_FINE_MODS;
        // special events: stop in/out, frame loss in/out; new edges merge with pending
        ev = st_q.ev_pend | {st_q.run & ~stamp_run, ~st_q.run & stamp_run,
                             st_q.frm & ~time_frame_ok, ~st_q.frm & time_frame_ok};
        st_d.run = stamp_run;
        st_d.frm = time_frame_ok;
        if (ev != 4'h0) begin
            have = 1'b1;
            if (ev[3] | ev[2]) begin
                wr_msg = mk_msg(`IETSR_SLOT_SPECIAL, `IETSR_EV_STOP, ev[3], st_q.now);
                ev     = ev & (ev[3] ? 4'h7 : 4'hb);
            end else begin
                wr_msg = mk_msg(`IETSR_SLOT_SPECIAL, `IETSR_EV_FRAME, ev[1], st_q.now);
                ev     = ev & (ev[1] ? 4'hd : 4'he);
            end
        end else begin
            // one channel per cycle; native slots and channels past the station limit are skipped
            cur      = digital_input_channel[idx];
            eligible = stamp_enable[idx] & legacy_slot[idx[8:5]] & (st_q.elig < `IETSR_STATION_MAX);
            st_d.prev[idx] = cur;
            if (eligible) begin
                st_d.elig = st_q.elig + 8'h1;
            end
            if (eligible && stamp_run && (cur != st_q.prev[idx])) begin
                have   = 1'b1;
                wr_msg = mk_msg(idx[8:5] + `IETSR_SLOT_BASE, idx[4:0],
                                cur == incoming_on_rise[idx], st_q.now);
            end
            if (idx == 9'(`IETSR_CHANS - 1)) begin
                st_d.scan = 9'h0;
                st_d.elig = 8'h0;
            end else begin
                st_d.scan = idx + 9'h1;
            end
        end
        st_d.ev_pend = ev;
        // append to the open record, closing it when it reaches its length
        if (have) begin
            if (st_q.nrec < `IETSR_RECS) begin
                wr_en       = 1'b1;
                st_d.wr_cnt = st_q.wr_cnt + 5'h1;
                if (st_q.wr_cnt == `IETSR_MSG_PER_REC - 5'h1) begin
                    st_d.rec_len[st_q.wr_rec] = `IETSR_MSG_PER_REC;
                    st_d.wr_rec = nxt_rec(st_q.wr_rec);
                    st_d.wr_cnt = 5'h0;
                    inc_n       = 4'h1;
                end
            end else begin
                st_d.overflow = 1'b1;
            end
        end
        // readout of the oldest record on request
        case (st_q.rd)
            ietsr_pkg::ietsr_rd_idle: begin
                if (rd_req || st_q.rd_pend) begin
                    st_d.rd_pend = 1'b0;
                    if (st_q.nrec != 4'h0) begin
                        st_d.rd     = ietsr_pkg::ietsr_rd_run;
                        st_d.rd_idx = 5'h0;
                        st_d.rd_len = st_q.rec_len[st_q.rd_rec];
                    end else if (st_q.wr_cnt == 5'h0) begin
                        st_d.rec_empty = 1'b1;
                    end else if (!wr_en) begin
                        st_d.rec_len[st_q.wr_rec] = st_q.wr_cnt;
                        st_d.wr_rec = nxt_rec(st_q.wr_rec);
                        st_d.wr_cnt = 5'h0;
                        inc_n       = 4'h1;
                        st_d.rd     = ietsr_pkg::ietsr_rd_run;
                        st_d.rd_idx = 5'h0;
                        st_d.rd_len = st_q.wr_cnt;
                    end else begin
                        st_d.rd_pend = 1'b1;
                    end
                end
            end
            ietsr_pkg::ietsr_rd_run: begin
                st_d.msg_valid = 1'b1;
                if (st_q.rd_idx == st_q.rd_len - 5'h1) begin
                    st_d.msg_last = 1'b1;
                    st_d.rd       = ietsr_pkg::ietsr_rd_tail;
                end else begin
                    st_d.rd_idx = st_q.rd_idx + 5'h1;
                end
                st_d.rd_pend = st_q.rd_pend | rd_req;
            end
            ietsr_pkg::ietsr_rd_tail: begin
                st_d.rd_rec   = nxt_rec(st_q.rd_rec);
                dec_n         = 4'h1;
                st_d.overflow = have & ~wr_en; // a message lost now wins over the clear
                st_d.rd       = ietsr_pkg::ietsr_rd_idle;
                st_d.rd_pend  = st_q.rd_pend | rd_req;
            end
            default: begin
                st_d.rd = ietsr_pkg::ietsr_rd_idle;
            end
        endcase
        st_d.nrec = st_q.nrec + inc_n - dec_n;
        st_d.irq  = (st_q.nrec != 4'h0) || (st_q.wr_cnt != 5'h0);
        // input image: both halves taken on one update, zero while not ready
        if (std_upd) begin
            st_d.img[HALF-1:0]      = std_ok ? std_in : '0;
            st_d.img[2*HALF-1:HALF] = ext_ok ? ext_in : '0;
            if (st_q.add_cnt >= 4'(ADD_DIV - 1)) begin
                st_d.add_cnt = 4'h0;
                st_d.add     = add_ok ? add_in : '0;
            end else begin
                st_d.add_cnt = st_q.add_cnt + 4'h1;
            end
        end
        // firmware: good load flips the boot image, restart deferred on the active redundant unit
        fw_new = fw_done & fw_ok & auto_activate;
        allow  = ~(redundant & unit_active);
        if (fw_done && fw_ok) begin
            st_d.boot_bank = ~st_q.boot_bank;
        end
        st_d.restart  = (st_q.rst_pend | fw_new) & allow;
        st_d.rst_pend = (st_q.rst_pend | fw_new) & ~allow;
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // message list memory
    ietsr_mem #(.W(`IETSR_MSG_W), .AW(9)) u_mem (
        .clk     (clk),
        .ce      (ce),
        .we      (wr_en),
        .waddr   (waddr),
        .wdata   (wr_msg),
        .raddr   (raddr),
        .rdata_q (msg_data)
    );

    // outputs straight from the state register
    assign msg_valid   = st_q.msg_valid;
    assign msg_last    = st_q.msg_last;
    assign rec_empty   = st_q.rec_empty;
    assign overflow    = st_q.overflow;
    assign irq         = st_q.irq;
    assign img_data    = st_q.img;
    assign add_data    = st_q.add;
    assign restart_req = st_q.restart;
    assign boot_bank   = st_q.boot_bank;
    assign res_coarse  = st_q.coarse;
    assign now_ms      = st_q.now;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_irq_pending: assert property (@(posedge clk) disable iff (!nrst)
        ce && (st_q.nrec != 4'h0 || st_q.wr_cnt != 5'h0) |=> irq)
        else $error("interrupt missing while messages pending");
    a_ext_zero: assert property (@(posedge clk) disable iff (!nrst)
        ce && std_upd && !ext_ok |=> img_data[2*HALF-1:HALF] == '0)
        else $error("expanded data not zero for absent module");
    a_halves_same: assert property (@(posedge clk) disable iff (!nrst)
        ce && std_upd && std_ok && ext_ok |=> img_data == {$past(ext_in), $past(std_in)})
        else $error("image halves not refreshed together");
    a_add_slow: assert property (@(posedge clk) disable iff (!nrst)
        ce && std_upd && st_q.add_cnt < 4'(ADD_DIV - 1) |=> $stable(add_data))
        else $error("additional data refreshed too often");
    a_rec_bound: assert property (@(posedge clk) disable iff (!nrst)
        st_q.nrec <= `IETSR_RECS && st_q.wr_cnt < `IETSR_MSG_PER_REC)
        else $error("record count or record length exceeded");
    a_slot_field: assert property (@(posedge clk) disable iff (!nrst)
        msg_valid |-> msg_data[`IETSR_MSG_SLOT_LSB +: 4] >= `IETSR_SLOT_BASE
                   || msg_data[`IETSR_MSG_SLOT_LSB +: 4] == `IETSR_SLOT_SPECIAL)
        else $error("message slot outside legal range");
    a_stop_msg: assert property (@(posedge clk) disable iff (!nrst)
        ce && st_q.run && !stamp_run && st_q.nrec < 4'he |-> ##[0:2] (wr_en && wr_msg[47:44] == `IETSR_SLOT_SPECIAL))
        else $error("stop of stamping gave no special message");
    a_station_cap: assert property (@(posedge clk) disable iff (!nrst)
        st_q.elig <= `IETSR_STATION_MAX)
        else $error("more channels stamped than station allows");
    a_oldest_first: assert property (@(posedge clk) disable iff (!nrst)
        ce && st_q.rd == ietsr_pkg::ietsr_rd_tail |=> st_q.rd_rec == nxt_rec($past(st_q.rd_rec)))
        else $error("readout did not advance to next oldest record");
    a_restart_auto: assert property (@(posedge clk) disable iff (!nrst)
        ce && fw_done && fw_ok && auto_activate && !redundant |=> restart_req)
        else $error("no restart after good automatic load");
    a_bank_keep: assert property (@(posedge clk) disable iff (!nrst)
        ce && !(fw_done && fw_ok) |=> $stable(boot_bank))
        else $error("boot image changed without a good load");
    a_redund_hold: assert property (@(posedge clk) disable iff (!nrst)
        ce && redundant && unit_active |=> !restart_req)
        else $error("active redundant unit restarted");

endmodule // ietsr_top
`default_nettype wire

//--- dv/ietsr_master.sv
`default_nettype none
module ietsr_master (
    // clocking
    input  wire logic        clk,
    input  wire logic        nrst,
    // bench control
    input  wire logic        go,
    output logic             done,
    output logic             got_empty,
    output logic [4:0]       nwords,
    output logic [47:0]      words [0:19],
    // readout port of the recorder
    input  wire logic [47:0] msg_data,
    input  wire logic        msg_valid,
    input  wire logic        msg_last,
    input  wire logic        rec_empty,
    output logic             rd_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // one read-record request per go, then gather the answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_req <= 1'b0;
            done <= 1'b0;
            got_empty <= 1'b0;
            nwords <= 5'h00;
        end else begin
            rd_req <= go;
            if (go) begin
                done <= 1'b0;
                got_empty <= 1'b0;
                nwords <= 5'h00;
            end
            if (msg_valid) begin
                words[nwords] <= msg_data;
                nwords <= nwords + 5'h01;
                done <= msg_last;
            end
            if (rec_empty) begin
                done <= 1'b1;
                got_empty <= 1'b1;
            end
        end
    end
endmodule // ietsr_master
`default_nettype wire

//--- dv/ietsr_top_test.sv
`default_nettype none
module ietsr_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, go, done, got_empty, rd_req;
    logic [383:0] dic, sen, inc;
    logic [11:0] leg;
    logic [3:0] mods;
    logic srun, tfok, tload, std_upd, std_ok, ext_ok, add_ok, fw_done, fw_ok, auto_act;
    logic [31:0] time_in, now_ms;
    logic [127:0] std_in, ext_in, add_in, add_data;
    logic [255:0] img;
    logic [47:0] msg_data;
    logic [47:0] words [0:19];
    logic [4:0] nwords;
    logic msg_valid, msg_last, rec_empty, irq, restart_req, boot_bank, res_coarse, overflow, red, uact;
    int error_cnt = 0;
    int num_checks = 0;
    int k;

    ietsr_top #(.TICK_CYC(8), .ADD_DIV(4)) dut_u (.clk(clk), .nrst(nrst), .ce(1'b1),
        .digital_input_channel(dic), .stamp_enable(sen), .incoming_on_rise(inc), .legacy_slot(leg),
        .modules_fitted(mods), .stamp_run(srun), .time_frame_ok(tfok), .time_load(tload), .time_in(time_in),
        .rd_req(rd_req), .msg_data(msg_data), .msg_valid(msg_valid), .msg_last(msg_last),
        .rec_empty(rec_empty), .overflow(overflow), .irq(irq), .std_upd(std_upd), .std_in(std_in), .std_ok(std_ok),
        .ext_in(ext_in), .ext_ok(ext_ok), .add_in(add_in), .add_ok(add_ok), .img_data(img),
        .add_data(add_data), .fw_done(fw_done), .fw_ok(fw_ok), .auto_activate(auto_act),
        .redundant(red), .unit_active(uact), .restart_req(restart_req), .boot_bank(boot_bank),
        .res_coarse(res_coarse), .now_ms(now_ms));

    ietsr_master master_u (.clk(clk), .nrst(nrst), .go(go), .done(done), .got_empty(got_empty),
        .nwords(nwords), .words(words), .msg_data(msg_data), .msg_valid(msg_valid),
        .msg_last(msg_last), .rec_empty(rec_empty), .rd_req(rd_req));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic cmp(input string what, input logic [255:0] exp, input logic [255:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one read-record request, bounded wait for the whole record
    task automatic fetch();
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        for (k = 0; k < 100 && !done; k++) cyc(1);
        if (!done) begin
            error_cnt++;
            $display("wrong value fetch expected done seen hang");
            close_out();
        end
    endtask

    task automatic upd();
        std_upd = 1'b1;
        cyc(1);
        std_upd = 1'b0;
        cyc(1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_image();
        std_in = 128'h0f0e0d0c0b0a09080706050403020100;
        ext_in = 128'h1f1e1d1c1b1a19181716151413121110;
        add_in = 128'h5a5a5a5a5a5a5a5a5a5a5a5a5a5a5a5a;
        upd();
        cmp("img_data", {128'h0, std_in}, img);
        ext_ok = 1'b1;
        upd();
        cmp("img_data", {ext_in, std_in}, img);
        std_ok = 1'b0;
        upd();
        cmp("img_data", {ext_in, 128'h0}, img);
        upd();
        cmp("add_data", add_in, add_data);
        $display("test image done");
    endtask

    // channel 0 incoming on rise, channel 1 incoming on fall, both rise together
    task automatic t_stamp();
        srun = 1'b1;
        cyc(5);
        fetch();
        cmp("nwords", 1, nwords);
        cmp("word0 head", 16'h2080, words[0][47:32]);
        leg = 12'h001;
        sen[1:0] = 2'h3;
        inc[0] = 1'b1;
        dic[1:0] = 2'h3;
        cyc(800);
        cmp("irq", 1, irq);
        fetch();
        cmp("nwords", 2, nwords);
        cmp("word0 head", 16'h4040, words[0][47:32]);
        cmp("word1 head", 16'h4080, words[1][47:32]);
        cmp("word0 time", 1, words[0][31:0] >= 32'h00001000);
        cyc(3);
        cmp("irq", 0, irq);
        $display("test stamp done");
    endtask

    task automatic t_special();
        srun = 1'b0;
        cyc(50);
        srun = 1'b1;
        cyc(50);
        fetch();
        cmp("nwords", 2, nwords);
        cmp("word0 head", 16'h20c0, words[0][47:32]);
        cmp("word1 head", 16'h2080, words[1][47:32]);
        $display("test special done");
    endtask

    // a native slot toggles but must stay silent; past 128 enabled channels nothing is stamped
    task automatic t_native();
        sen[32] = 1'b1;
        dic[32] = 1'b1;
        cyc(800);
        cmp("irq", 0, irq);
        fetch();
        cmp("rec_empty", 1, got_empty);
        sen = '1;
        leg = 12'hfff;
        cyc(400);
        dic[128:127] = 2'h3;
        cyc(800);
        fetch();
        cmp("nwords", 1, nwords);
        cmp("word0 head", 16'h7f80, words[0][47:32]);
        $display("test native done");
    endtask

    task automatic t_firmware();
        int pulses;
        pulses = 0;
        fw_ok = 1'b1;
        fw_done = 1'b1;
        cyc(1);
        fw_done = 1'b0;
        repeat (4) begin
            pulses += restart_req;
            cyc(1);
        end
        cmp("restart pulses", 1, pulses);
        cmp("boot_bank", 1, boot_bank);
        fw_ok = 1'b0;
        fw_done = 1'b1;
        cyc(1);
        fw_done = 1'b0;
        repeat (4) begin
            pulses += restart_req;
            cyc(1);
        end
        cmp("restart pulses", 1, pulses);
        cmp("boot_bank", 1, boot_bank);
        cmp("res_coarse", 0, res_coarse);
        mods = 4'h9;
        cyc(3);
        cmp("res_coarse", 1, res_coarse);
        {red, uact, fw_ok, fw_done} = 4'hf;
        cyc(1);
        fw_done = 1'b0;
        cyc(3);
        cmp("restart_req", 0, restart_req);
        cmp("boot_bank", 0, boot_bank);
        uact = 1'b0;
        cyc(1);
        cmp("restart_req", 1, restart_req);
        $display("test firmware done");
    endtask

    // stamping toggled every cycle fills all 15 records, later messages are lost
    task automatic t_overflow();
        repeat (310) begin
            srun = ~srun;
            cyc(1);
        end
        cmp("overflow", 1, overflow);
        fetch();
        cmp("nwords", 20, nwords);
        cmp("word0 head", 16'h20c0, words[0][47:32]);
        cmp("overflow", 0, overflow);
        $display("test overflow done");
    endtask

    // ----------------------------------------------------------------
    // main sequence; t_native enables every channel to push past the 128-channel station limit
    // ----------------------------------------------------------------
    initial begin
        {nrst, go, srun, tfok, tload, std_upd, fw_done, fw_ok, auto_act, red, uact} = '0;
        {dic, sen, inc, leg} = '0;
        {std_ok, ext_ok, add_ok} = 3'h5;
        {std_in, ext_in, add_in} = '0;
        mods = 4'h8;
        time_in = 32'h00001000;
        auto_act = 1'b1;
        cyc(16);
        nrst = 1'b1;
        cyc(2);
        tload = 1'b1;
        cyc(1);
        tload = 1'b0;
        cmp("now_ms", 32'h1000, now_ms);
        cyc(8);
        cmp("now_ms", 32'h1001, now_ms);
        add_ok = 1'b1;
        t_image();
        t_stamp();
        t_special();
        t_native();
        t_firmware();
        t_overflow();
        close_out();
    end
endmodule // ietsr_top_test
`default_nettype wire
